/* File: logic/smba_consts.svh */
// constants for the smbus slave port with alert and bus timeout
// assumes a 100 MHz core clock and an 8-bit register pointer space
// How it works
// - on an own-address match the port pulls sda low in the following ack slot.
// - the pointer byte and the first data byte of a write are acknowledged in the ninth slot; a third byte is not.
// - a read returns exactly one byte from the register the pointer selects.
// - the open-drain alert line is pulled low while an alert is pending.
// - the port answers the alert response read only while alerting, returning its address.
// - while answering the alert read the port arbitrates per bit and withdraws on a loss.
// - after the alert answer the master reads status; alert drops only once the cause is gone.
// - with the timeout on, a bus silent for 25 ms makes the port release sda and abort.
// - bit six of the first configuration register disables the timeout when 1, reset 0.
// - a value beyond its high or low limit asserts the alert output.
// - the first byte after the address sets the pointer, a second one writes that register.
// - the slave address is five fixed upper bits and two strapped low bits.
`ifndef SMBA_CONSTS_SVH
`define SMBA_CONSTS_SVH
`define SMBA_ADDR_HI 5'h0B
`define SMBA_ARA 7'h0C
`define SMBA_CFG1_OFS 8'h40
`define SMBA_CFG1_RST 8'h00
`define SMBA_TO_OFF_BIT 6
`define SMBA_LAST_BIT 3'h7
`define SMBA_IDX_PTR 2'h0
`define SMBA_IDX_DATA 2'h1
`define SMBA_IDX_MAX 2'h2
`define SMBA_CLK_KHZ 100000
`define SMBA_TO_MS 25
`define SMBA_TO_CYC (`SMBA_TO_MS * `SMBA_CLK_KHZ)
`define SMBA_CNT_W 22
`endif

/* File: logic/smba_pkg.sv */
// types shared by the smbus slave port and its pin synchroniser
// assumes nothing beyond a sv-2012 compiler
package smba_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_TXACK = 3'b101,
    ST_SKIP = 3'b110
  } smba_state_t;
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } smba_line_t;
  typedef struct packed {
    logic strobe;
    logic [7:0] addr;
    logic [7:0] data;
  } smba_wr_t;
endpackage

/* File: logic/smba_pin_sync.sv */
// two-flop synchroniser for one pin with edge pulses
// assumes the pin is asynchronous to clk
`timescale 1ns/10ps
module smba_pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // raw pin and clean result
  input wire logic pin_in,
  output smba_pkg::smba_line_t line
);
  import smba_pkg::*;
  logic s1;
  logic s2;
  logic s3;
  // first stage feeds only the second; pins idle high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // level and one-cycle edge pulses from settled stages
  always_comb begin
    line.level = s2;
    line.rise = s2 & ~s3;
    line.fall = ~s2 & s3;
  end
endmodule

/* File: logic/smba_port.sv */
// smbus slave engine: write byte, send byte, receive byte, alert answer, timeout
// assumes scl, sda and straps are raw pins; register data comes from same-clock logic
`timescale 1ns/10ps
`include "smba_consts.svh"
module smba_port #(
  parameter int TO_CYC = `SMBA_TO_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // smbus pins, sda open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // alert pin, open drain
  output logic alert_out,
  output logic alert_oe,
  // address straps
  input wire logic addr_sel1,
  input wire logic addr_sel0,
  // limit comparators
  input wire logic limit_exceed,
  // register side
  output logic [7:0] reg_ptr,
  output smba_pkg::smba_wr_t reg_wr,
  input wire logic [7:0] reg_rd_data,
  output logic [7:0] device_config_one
);
  import smba_pkg::*;
  smba_line_t scl;
  smba_line_t sda;
  smba_line_t sel1;
  smba_line_t sel0;
  smba_state_t state;
  logic [6:0] my_addr;
  logic [7:0] sr;
  logic [2:0] bitc;
  logic got8;
  logic rw;
  logic is_ara;
  logic [1:0] byte_idx;
  logic rd_done;
  logic ara_done;
  logic [`SMBA_CNT_W-1:0] to_cnt;
  logic to_hit;
  logic start;
  logic stop;
  logic own_hit;
  logic ara_hit;
  logic [7:0] tx_byte;

  smba_pin_sync u_scl (.clk(clk), .nrst(nrst), .pin_in(scl_in), .line(scl));
  smba_pin_sync u_sda (.clk(clk), .nrst(nrst), .pin_in(sda_in), .line(sda));
  smba_pin_sync u_sel1 (.clk(clk), .nrst(nrst), .pin_in(addr_sel1), .line(sel1));
  smba_pin_sync u_sel0 (.clk(clk), .nrst(nrst), .pin_in(addr_sel0), .line(sel0));

  // bus conditions and address decode
  always_comb begin
    start = sda.fall & scl.level;
    stop = sda.rise & scl.level;
    own_hit = (sr[7:1] == my_addr);
    ara_hit = (sr[7:1] == `SMBA_ARA) & sr[0] & alert_oe;
    to_hit = (to_cnt == `SMBA_CNT_W'(TO_CYC - 1));
  end

  // byte to send: own address for alert answer, else selected register
  always_comb begin
    if (is_ara) begin
      tx_byte = {my_addr, 1'b0};
    end else if (reg_ptr == `SMBA_CFG1_OFS) begin
      tx_byte = device_config_one;
    end else begin
      tx_byte = reg_rd_data;
    end
  end

  // strapped slave address, resampled every cycle after reset release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      my_addr <= {`SMBA_ADDR_HI, 2'h0};
    end else begin
      my_addr <= {`SMBA_ADDR_HI, sel1.level, sel0.level};
    end
  end

  // idle-bus watchdog, cleared by any edge on either line
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      to_cnt <= '0;
    end else if (state == ST_IDLE || device_config_one[`SMBA_TO_OFF_BIT]
                 || scl.rise || scl.fall || sda.rise || sda.fall) begin
      to_cnt <= '0;
    end else if (!to_hit) begin
      to_cnt <= to_cnt + 1'b1;
    end
  end

  // transaction engine
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      sr <= 8'h00;
      bitc <= 3'h0;
      got8 <= 1'b0;
      rw <= 1'b0;
      is_ara <= 1'b0;
      byte_idx <= `SMBA_IDX_PTR;
      sda_oe <= 1'b0;
      reg_ptr <= 8'h00;
      reg_wr <= '0;
      rd_done <= 1'b0;
    end else begin
      reg_wr.strobe <= 1'b0;
      rd_done <= 1'b0;
      if (start) begin
        state <= ST_ADDR;
        bitc <= 3'h0;
        got8 <= 1'b0;
        is_ara <= 1'b0;
        byte_idx <= `SMBA_IDX_PTR;
        sda_oe <= 1'b0;
      end else if (stop || (to_hit && state != ST_IDLE)) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_RX: begin
            if (scl.rise) begin
              sr <= {sr[6:0], sda.level};
              bitc <= bitc + 1'b1;
              got8 <= (bitc == `SMBA_LAST_BIT);
            end else if (scl.fall && got8) begin
              got8 <= 1'b0;
              if (state == ST_ADDR) begin
                rw <= sr[0];
                is_ara <= ara_hit & ~own_hit;
                if (own_hit || ara_hit) begin
                  sda_oe <= 1'b1;
                  state <= ST_ACK;
                end else begin
                  state <= ST_SKIP;
                end
              end else if (byte_idx == `SMBA_IDX_PTR) begin
                reg_ptr <= sr;
                byte_idx <= `SMBA_IDX_DATA;
                sda_oe <= 1'b1;
                state <= ST_ACK;
              end else if (byte_idx == `SMBA_IDX_DATA) begin
                reg_wr <= '{strobe: 1'b1, addr: reg_ptr, data: sr};
                byte_idx <= `SMBA_IDX_MAX;
                sda_oe <= 1'b1;
                state <= ST_ACK;
              end else begin
                state <= ST_SKIP;
              end
            end
          end
          ST_ACK: begin
            if (scl.fall) begin
              bitc <= 3'h0;
              if (rw) begin
                sr <= {tx_byte[6:0], 1'b0};
                sda_oe <= ~tx_byte[7];
                state <= ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl.rise) begin
              bitc <= bitc + 1'b1;
              got8 <= (bitc == `SMBA_LAST_BIT);
              if (!sda_oe && !sda.level) begin
                state <= ST_SKIP;
              end
            end else if (scl.fall) begin
              if (got8) begin
                got8 <= 1'b0;
                sda_oe <= 1'b0;
                state <= ST_TXACK;
              end else begin
                sda_oe <= ~sr[7];
                sr <= {sr[6:0], 1'b0};
              end
            end
          end
          ST_TXACK: begin
            if (scl.rise) begin
              rd_done <= ~is_ara;
              state <= ST_SKIP;
            end
          end
          ST_SKIP, ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // local copy of the first configuration register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      device_config_one <= `SMBA_CFG1_RST;
    end else if (reg_wr.strobe && reg_wr.addr == `SMBA_CFG1_OFS) begin
      device_config_one <= reg_wr.data;
    end
  end

  // alert answer completed; armed until the alert is released
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ara_done <= 1'b0;
    end else if (state == ST_TXACK && is_ara && scl.rise) begin
      ara_done <= 1'b1;
    end else if (!alert_oe) begin
      ara_done <= 1'b0;
    end
  end

  // alert pull-down: set wins, release only after answer, read and cause gone
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alert_oe <= 1'b0;
    end else if (limit_exceed) begin
      alert_oe <= 1'b1;
    end else if (ara_done && rd_done) begin
      alert_oe <= 1'b0;
    end
  end

  // open-drain data values never go high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_out <= 1'b0;
      alert_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      alert_out <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_ack_drive: assert property ((state == ST_ACK) |-> sda_oe)
    else $error("ack slot not driven low");
  chk_data_ack: assert property ((state == ST_RX && scl.fall && got8 && !start && !stop
      && !to_hit && byte_idx != `SMBA_IDX_MAX) |=> state == ST_ACK && sda_oe)
    else $error("write byte not acknowledged");
  chk_skip_release: assert property ((state == ST_SKIP) |=> !sda_oe)
    else $error("sda held after mismatch");
  chk_alert_set: assert property (limit_exceed |=> alert_oe && !alert_out)
    else $error("limit did not raise alert");
  chk_alert_hold: assert property (alert_oe && !(ara_done && rd_done) |=> alert_oe)
    else $error("alert dropped without answer and read");
  chk_ara_gate: assert property ((state == ST_TX && is_ara) |-> alert_oe)
    else $error("alert answer while not alerting");
  chk_arb_loss: assert property ((state == ST_TX && scl.rise && !sda_oe && !sda.level
      && !start && !stop && !to_hit) |=> state == ST_SKIP ##1 !sda_oe)
    else $error("arbitration loss not honoured");
  chk_timeout_rel: assert property ((to_hit && state != ST_IDLE && !start)
      |=> state == ST_IDLE && !sda_oe)
    else $error("timeout did not release bus");
  chk_to_off: assert property (device_config_one[`SMBA_TO_OFF_BIT] |=> to_cnt == '0)
    else $error("timeout ran while disabled");
  chk_one_byte: assert property ((state == ST_TXACK && scl.rise && !start && !stop
      && !to_hit) |=> state == ST_SKIP)
    else $error("more than one byte sent");
  chk_ptr_write: assert property (reg_wr.strobe
      |-> reg_wr.addr == reg_ptr ##1 !reg_wr.strobe)
    else $error("write strobe malformed");

  // per-step checks of ack release, pointer load, mismatch, alert answer
  chk_ack_release: assert property ((state == ST_ACK && scl.fall && !rw && !start && !stop
      && !to_hit) |=> state == ST_RX && !sda_oe)
    else $error("ack slot not released");
  chk_ptr_load: assert property ((state == ST_RX && scl.fall && got8 && !start && !stop
      && !to_hit && byte_idx == `SMBA_IDX_PTR) |=> reg_ptr == $past(sr))
    else $error("pointer not loaded from first byte");
  chk_mismatch_skip: assert property ((state == ST_ADDR && scl.fall && got8 && !own_hit
      && !ara_hit && !start && !stop && !to_hit) |=> state == ST_SKIP && !sda_oe)
    else $error("foreign address not ignored");
  chk_ara_first_bit: assert property ((state == ST_ACK && scl.fall && rw && is_ara
      && !start && !stop && !to_hit) |=> sda_oe == ~my_addr[6])
    else $error("alert answer msb wrong");
  chk_alert_clear: assert property ((ara_done && rd_done && !limit_exceed)
      |=> !alert_oe)
    else $error("alert not released after answer and read");

  cov_write: cover property (reg_wr.strobe);
  cov_read: cover property (rd_done);
  cov_ara: cover property (ara_done && !alert_oe);
  cov_timeout: cover property (to_hit && state != ST_IDLE);
  cov_arb_loss: cover property (state == ST_TX && scl.rise && !sda_oe && !sda.level);
endmodule

/* File: tb/smba_host.sv */
// behavioural smbus host master that drives scl and pulls sda
// assumes an external pull-up resolves sda; timing steps on the falling clk edge
`timescale 1ns/10ps
module smba_host (
  // clock
  input wire logic clk,
  // bus
  input wire logic sda_wire,
  output logic scl,
  output logic sda_pull
);
  // bus idles high, scl stands still between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // quarter of a 160 ns scl period
  task automatic q;
    repeat (4) @(negedge clk);
  endtask
  // start, also usable as repeated start
  task automatic start;
    sda_pull = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  // stop: sda rises while scl high
  task automatic stop;
    sda_pull = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b0;
    q();
  endtask
  // one bit: data set in low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    q();
    scl = 1'b1;
    q();
    r = sda_wire;
    q();
    scl = 1'b0;
    q();
  endtask
  // byte msb first, ninth slot left released (no-ack on reads)
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
endmodule

/* File: tb/smbus_slave_alert_port_bench.sv */
// self-checking bench for the smbus slave port with alert and timeout
// assumes smba_host as the far side and a pull-up on sda and alert
`timescale 1ns/10ps
module smbus_slave_alert_port_bench;
  import smba_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic addr_sel1 = 1'b0;
  logic addr_sel0 = 1'b0;
  logic limit_exceed = 1'b0;
  logic sda_out, sda_oe, alert_out, alert_oe, scl, host_pull, sda_wire, alert_wire, a;
  logic [7:0] reg_ptr, reg_rd_data, device_config_one, p, d, v;
  logic [7:0] cfg_model = 8'h00;
  logic [6:0] own;
  smba_wr_t reg_wr, last_wr;
  int miscompares = 0;
  int samples_checked = 0;
  int wr_count = 0;
  int n;
  int unsigned seed_sink;
  // 100 MHz clock
  always #5 clk = ~clk;
  // open-drain wires with pull-ups
  assign sda_wire = !(sda_oe | host_pull);
  assign alert_wire = !alert_oe;
  // register file stand-in
  assign reg_rd_data = ~reg_ptr;
  smba_port #(.TO_CYC(200)) u_dut (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .alert_out(alert_out), .alert_oe(alert_oe),
    .addr_sel1(addr_sel1), .addr_sel0(addr_sel0), .limit_exceed(limit_exceed),
    .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_rd_data(reg_rd_data),
    .device_config_one(device_config_one));
  smba_host u_host (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(host_pull));
  // capture register write strobes
  always @(posedge clk) begin
    if (reg_wr.strobe === 1'b1) begin
      last_wr <= reg_wr;
      wr_count <= wr_count + 1;
    end
  end
  // compare and report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // expected read data for a pointer
  function automatic logic [7:0] exp_rd(input logic [7:0] ptr);
    return (ptr == 8'h40) ? cfg_model : ~ptr;
  endfunction
  // send byte (n=1), write byte (n=2), or write byte plus a refused third byte (n=3)
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] dat,
                    input int nb, input logic ea);
    logic k;
    logic [7:0] r;
    u_host.start();
    u_host.xfer({dev, 1'b0}, r, k);
    check({7'h00, k}, {7'h00, ea});
    if (ea) begin
      u_host.xfer(ptr, r, k);
      check({7'h00, k}, 8'h01);
      if (nb > 1) begin
        u_host.xfer(dat, r, k);
        check({7'h00, k}, 8'h01);
        if (nb > 2) begin
          u_host.xfer(dat, r, k);
          check({7'h00, k}, 8'h00);
        end
      end
    end
    u_host.stop();
  endtask
  // receive byte, one byte then no-ack and stop
  task automatic rd(input logic [6:0] dev, output logic [7:0] dat, output logic k);
    logic na;
    u_host.start();
    u_host.xfer({dev, 1'b1}, dat, k);
    dat = 8'hFF;
    if (k) u_host.xfer(8'hFF, dat, na);
    u_host.stop();
  endtask
  // main sequence
  initial begin
    seed_sink = $urandom(32'hB810);
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    check({4'h0, sda_out, alert_out, sda_oe, alert_oe}, 8'h00);
    check(device_config_one, 8'h00);
    // every strap setting: write, foreign address, pointer only, read back
    for (int i = 0; i < 4; i++) begin
      {addr_sel1, addr_sel0} = i[1:0];
      own = {5'h0B, i[1:0]};
      repeat (8) @(negedge clk);
      p = $urandom;
      if (p == 8'h40) p = 8'h41;
      d = $urandom;
      n = wr_count;
      wr(own, p, d, 3, 1'b1);
      check(reg_ptr, p);
      check(last_wr.addr, p);
      check(last_wr.data, d);
      wr(own ^ 7'h10, ~p, d, 2, 1'b0);
      check(reg_ptr, p);
      wr(own, ~p, 8'h00, 1, 1'b1);
      check(8'(wr_count - n), 8'h01);
      rd(own, v, a);
      check({7'h00, a}, 8'h01);
      check(v, exp_rd(~p));
    end
    // bus stall with timeout disabled, then enabled
    for (int m = 1; m >= 0; m--) begin
      cfg_model = m[0] ? 8'h40 : 8'h00;
      wr(own, 8'h40, cfg_model, 2, 1'b1);
      check(device_config_one, cfg_model);
      wr(own, 8'hC3, 8'h00, 1, 1'b1);
      u_host.start();
      u_host.xfer({own, 1'b1}, v, a);
      repeat (8) @(negedge clk);
      check({7'h00, sda_oe}, 8'h01);
      repeat (300) @(negedge clk);
      check({7'h00, sda_oe}, {7'h00, m[0]});
      u_host.xfer(8'hFF, v, a);
      if (m == 1) check(v, 8'h3C);
      u_host.stop();
    end
    // alert raise, identification and release
    rd(7'h0C, v, a);
    check({7'h00, a}, 8'h00);
    limit_exceed = 1'b1;
    @(negedge clk);
    limit_exceed = 1'b0;
    @(negedge clk);
    check({7'h00, alert_wire}, 8'h00);
    rd(own, v, a);
    check({7'h00, alert_oe}, 8'h01);
    // a lower-addressed rival pulls sda during the alert answer
    u_host.start();
    u_host.xfer({7'h0C, 1'b1}, v, a);
    check({7'h00, a}, 8'h01);
    u_host.xfer(8'h58, v, a);
    check(v, 8'h58 & {own, 1'b0});
    u_host.stop();
    rd(own, v, a);
    check({7'h00, alert_oe}, 8'h01);
    rd(7'h0C, v, a);
    check({7'h00, a}, 8'h01);
    check(v, {own, 1'b0});
    check({7'h00, alert_oe}, 8'h01);
    rd(own, v, a);
    check({7'h00, alert_oe}, 8'h00);
    complete_run();
  end
  // watchdog: run needs about 10k cycles, allow 50k
  initial begin
    #500000;
    miscompares++;
    complete_run();
  end
endmodule
